//--- hcs_master.sv
// bus master model: bit-bangs the two-wire bus toward the hub slave
// assumes a pull-up on the data line; it only ever pulls the data line low
`timescale 1ns/10ps
`default_nettype none
module hcs_master
(
  input  wire logic sys_clk,
  input  wire logic sda_line,
  output var logic  scl_pin,
  output var logic  sda_pull
);
  localparam int HALF = 100; // 5 us phases: 100 kHz, well above the slave's minimum

  // the bus clock is ours alone and idles high
  initial scl_pin = 1'b1;
  initial sda_pull = 1'b0;

  // wait n edges, then step clear of the edge before touching a pin
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  // one slot: data set in clock low, read back at the end of clock high
  task automatic slot(input logic b, output logic r);
    sda_pull = !b;
    cyc(HALF);
    scl_pin = 1'b1;
    cyc(HALF);
    r = sda_line;
    scl_pin = 1'b0;
    cyc(5);
  endtask

  // start, also used as repeated start with no stop before it
  task automatic start();
    sda_pull = 1'b0;
    cyc(HALF);
    scl_pin = 1'b1;
    cyc(HALF);
    sda_pull = 1'b1;
    cyc(HALF);
    scl_pin = 1'b0;
    cyc(5);
  endtask

  // stop: data rises while clock high, ending any transfer
  task automatic stop();
    sda_pull = 1'b1;
    cyc(HALF);
    scl_pin = 1'b1;
    cyc(HALF);
    sda_pull = 1'b0;
    cyc(HALF);
  endtask

  // byte out msb first, then the slave's acknowledge slot
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      slot(d[i], r);
    slot(1'b1, r);
    ack = !r;
  endtask

  // byte in; ack low on the last byte closes the read
  task automatic get_byte(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      slot(1'b1, d[i]);
    slot(!ack, r);
  endtask
endmodule // hcs_master
`default_nettype wire

//--- hcs_pkg.sv
// package for the hub command/data two-wire slave: constants, types, state layout
// assumes one system clock; all pins enter through the two-flop synchroniser
package hcs_pkg;

  // bus addresses, msb first
  localparam logic [6:0] HCS_CMD_ADDR  = 7'h1B;
  localparam logic [6:0] HCS_DATA_ADDR = 7'h1A;

  // timing: sample/drive delay after a bus clock edge
  localparam int         HCS_SYS_CLK_MHZ  = 20;
  localparam int         HCS_EDGE_DLY_NS  = 1000;
  localparam int         HCS_EDGE_DLY_INT = (HCS_EDGE_DLY_NS * HCS_SYS_CLK_MHZ + 999) / 1000;
  localparam logic [4:0] HCS_EDGE_DLY_CYC = 5'(HCS_EDGE_DLY_INT);

  // auxiliary clock: crystal rate over output rate, half period in cycles
  localparam int         HCS_XTAL_MHZ     = 48;
  localparam int         HCS_AUX_MHZ      = 12;
  localparam logic [1:0] HCS_AUX_HALF_CYC = 2'(HCS_XTAL_MHZ / (2 * HCS_AUX_MHZ));

  // cycles after reset before straps are taken (synchroniser depth)
  localparam logic [1:0] HCS_STRAP_WAIT = 2'h2;

  // byte bookkeeping
  localparam logic [3:0] HCS_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] HCS_LAST_BIT      = 4'h7;

  typedef enum logic [2:0] {HCS_ST_IDLE, HCS_ST_RECV, HCS_ST_ACK, HCS_ST_SEND,
                            HCS_ST_MACK} hcs_st_e_t;

  typedef enum logic [1:0] {HCS_PH_ADDR, HCS_PH_CMD, HCS_PH_WR, HCS_PH_RD} hcs_ph_e_t;

  // byte stream toward the memory management unit
  typedef struct packed {
    logic       cmd_valid;  // one-cycle pulse: command byte in data
    logic       wr_valid;   // one-cycle pulse: data byte in data
    logic       rd_take;    // one-cycle pulse: rd_byte was loaded
    logic [7:0] data;       // received byte
    logic [7:0] ctx;        // command in force for this byte
  } hcs_mmu_t;

  // whole state of the top module
  typedef struct packed {
    hcs_st_e_t  st;
    hcs_ph_e_t  ph;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic       byte_done;
    logic       ack_ok;
    logic [4:0] dly_cnt;
    logic       dly_run;
    logic       dly_smp;
    logic       scl_d;
    logic       sda_d;
    logic       sda_oe;
    logic       od_low;
    logic       irq_oe;
    hcs_mmu_t   mmu;
    logic [7:0] last_cmd;
    logic       mode1;
    logic [1:0] strap_cnt;
    logic       strap_done;
    logic [3:0] oc_flag;
    logic [3:0] ind_n;
    logic [1:0] aux_cnt;
    logic       aux_clk;
  } hcs_state_t;

  localparam hcs_state_t HCS_STATE_RST = '0;

endpackage

//--- hcs_props.sv
// concurrent checks on the ports of the hub two-wire slave
// assumes one clock domain (sys_clk) and the bench's 100 kHz bus timing
`timescale 1ns/10ps
`default_nettype none
module hcs_props
  import hcs_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       irq_out_n,
  input wire logic       irq_oe,
  input wire logic       attention_req,
  input wire hcs_mmu_t   mmu_out,
  input wire logic [7:0] rd_byte,
  input wire logic       mode_select_a,
  input wire logic       mode_select_b,
  input wire logic       mode1,
  input wire logic [3:0] port_overcurrent,
  input wire logic [3:0] port_enabled,
  input wire logic       port2_indicator_out_n,
  input wire logic [2:0] port_indicator_out_n,
  input wire logic       aux_clock_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // interrupt pin follows the request one cycle late, pulling low only
  a_irq_follow: assert property (!$past(srst) && !$past(srst, 2) |->
    irq_oe == $past(attention_req) && irq_out_n == 1'b0) else $error("irq pin wrong");
  // data line moves only in clock low, about one microsecond after the fall
  a_sda_chg_late: assert property (!$stable(sda_oe) |->
    !$past(scl_in, 20) && $past(scl_in, 30) && sda_out == 1'b0) else $error("sda moved");
  // aux clock: two cycles high, two low
  a_aux_period: assert property (!$stable(aux_clock_out) |=>
    $stable(aux_clock_out) ##1 !$stable(aux_clock_out)) else $error("aux period");
  // mode 0 never reports over-current
  a_oc_mode0: assert property (!mode1 |-> port_overcurrent == 4'h0)
    else $error("oc in mode 0");
  // mode 1 parks the shared indicator pins
  a_ind_mode1: assert property (mode1 && $past(mode1) |->
    port_indicator_out_n == 3'h7) else $error("indicators in mode 1");
  // port 2 indicator kept in both modes
  a_ind_port2: assert property (!$past(srst) && !$past(srst, 2) |->
    port2_indicator_out_n == !$past(port_enabled[0])) else $error("port 2 indicator");
  // byte strobes are single: neither is high in the cycle after a strobe
  a_pulse_single: assert property (mmu_out.cmd_valid || mmu_out.wr_valid |=>
    !mmu_out.cmd_valid && !mmu_out.wr_valid) else $error("strobe too long");
  // a command byte becomes the context of what follows
  a_cmd_ctx: assert property (mmu_out.cmd_valid |->
    mmu_out.ctx == mmu_out.data && !mmu_out.wr_valid) else $error("ctx not command");
  // first read bit goes out with the load of the byte
  a_rd_first_bit: assert property (mmu_out.rd_take |->
    sda_oe == !$past(rd_byte[7])) else $error("first read bit");
  // mode 1 only with both straps high
  a_mode_straps: assert property (mode1 |-> mode_select_a && mode_select_b)
    else $error("mode without straps");

  c_cmd: cover property (mmu_out.cmd_valid);
  c_wr: cover property (mmu_out.wr_valid);
  c_rd: cover property (mmu_out.rd_take);
  c_mode1: cover property ($rose(mode1));
endmodule // hcs_props

bind hcs_slave hcs_props u_hcs_props (
  .sys_clk, .srst, .scl_in, .sda_out, .sda_oe, .irq_out_n, .irq_oe, .attention_req,
  .mmu_out, .rd_byte, .mode_select_a, .mode_select_b, .mode1, .port_overcurrent,
  .port_enabled, .port2_indicator_out_n, .port_indicator_out_n, .aux_clock_out);
`default_nettype wire

//--- hcs_slave.sv
// two-wire command/data slave of a compound hub, with mode straps and aux clock
// assumes the memory side runs on sys_clk; pins are asynchronous
`timescale 1ns/10ps
`default_nettype none
module hcs_slave
  import hcs_pkg::*;
(
  input  wire logic       sys_clk,                // system clock
  input  wire logic       srst,                   // synchronous reset
  input  wire logic       scl_in,                 // bus clock, input only
  input  wire logic       sda_in,                 // bus data level
  output logic            sda_out,                // level when driven, always low
  output logic            sda_oe,                 // high while pulling data low
  output logic            irq_out_n,              // level when driven, always low
  output logic            irq_oe,                 // high while interrupt asserted
  input  wire logic       attention_req,          // hub needs microcontroller
  output hcs_mmu_t        mmu_out,                // byte stream to memory unit
  input  wire logic [7:0] rd_byte,                // next byte to send on reads
  input  wire logic       mode_select_a,          // strap a
  input  wire logic       mode_select_b,          // strap b
  output logic            mode1,                  // straps chose mode 1
  input  wire logic       port2_overcurrent_in_n, // port 2 over-current pin
  input  wire logic       port3_overcurrent_in_n, // port 3 over-current pin
  input  wire logic       port4_overcurrent_in_n, // port 4 over-current pin
  input  wire logic       port5_overcurrent_in_n, // port 5 over-current pin
  output logic      [3:0] port_overcurrent,       // ports 5..2 over-current, high
  input  wire logic [3:0] port_enabled,           // ports 5..2 enabled status
  output logic            port2_indicator_out_n,  // port 2 indicator
  output logic      [2:0] port_indicator_out_n,   // ports 5..3 indicators
  output logic            aux_clock_out           // divided clock for outside
);

  hcs_state_t q;      // all registered state
  hcs_state_t nxt_q;  // next state
  logic [7:0] pin_s;  // synchronised pins

  // every pin passes two flops before use
  hcs_sync #(
    .W (8)
  ) u_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d_in    ({mode_select_b, mode_select_a, port5_overcurrent_in_n,
               port4_overcurrent_in_n, port3_overcurrent_in_n,
               port2_overcurrent_in_n, sda_in, scl_in}),
    .q_out   (pin_s)
  );

  logic       scl_s;  // synchronised bus clock
  logic       sda_s;  // synchronised bus data
  logic [3:0] oc_s;   // synchronised over-current, active low
  logic [1:0] ms_s;   // synchronised straps

  assign scl_s = pin_s[0];
  assign sda_s = pin_s[1];
  assign oc_s  = pin_s[5:2];
  assign ms_s  = pin_s[7:6];

  // next-state logic for the whole block
  always_comb
  begin
    logic       scl_rise;  // bus clock went high
    logic       scl_fall;  // bus clock went low
    logic       start_c;   // start or repeated start
    logic       stop_c;    // stop condition
    logic       fire_smp;  // sample point reached
    logic       fire_drv;  // drive point reached
    logic       load;      // fetch a byte to send
    logic [7:0] b;         // byte completed at this sample
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c  = 1'b0;
    stop_c   = 1'b0;
    fire_smp = 1'b0;
    fire_drv = 1'b0;
    load     = 1'b0;
    b        = {q.shreg[6:0], sda_s};

    nxt_q                = q;
    nxt_q.mmu.cmd_valid  = 1'b0;
    nxt_q.mmu.wr_valid   = 1'b0;
    nxt_q.mmu.rd_take    = 1'b0;
    nxt_q.scl_d          = scl_s;
    nxt_q.sda_d          = sda_s;
    nxt_q.od_low         = 1'b0;

    // bus events; clock is only ever watched, never driven
    scl_rise = scl_s & ~q.scl_d;
    scl_fall = ~scl_s & q.scl_d;
    start_c  = scl_s & q.scl_d & q.sda_d & ~sda_s;
    stop_c   = scl_s & q.scl_d & ~q.sda_d & sda_s;
    fire_smp = q.dly_run & (q.dly_cnt == 5'h01) & q.dly_smp;
    fire_drv = q.dly_run & (q.dly_cnt == 5'h01) & ~q.dly_smp;

    // one delay timer; rise and fall are microseconds apart so one serves both
    if ((scl_rise | scl_fall) && q.st != HCS_ST_IDLE)
    begin
      nxt_q.dly_run = 1'b1;
      nxt_q.dly_cnt = HCS_EDGE_DLY_CYC;
      nxt_q.dly_smp = scl_rise;
    end
    else if (q.dly_run)
    begin
      nxt_q.dly_cnt = q.dly_cnt - 5'h01;
      nxt_q.dly_run = (q.dly_cnt != 5'h01);
    end

    // sample point: the data line is read a delay after the clock rise
    if (fire_smp)
    begin
      case (q.st)
        HCS_ST_RECV:
        begin
          nxt_q.shreg   = b;
          nxt_q.bit_cnt = q.bit_cnt + 4'h1;
          if (q.bit_cnt == HCS_LAST_BIT)
          begin
            nxt_q.byte_done = 1'b1;
            nxt_q.ack_ok    = 1'b1;
            case (q.ph)
              HCS_PH_ADDR:
              begin
                // only a write may use the command address
                if (b[7:1] == HCS_CMD_ADDR && !b[0])
                  nxt_q.ph = HCS_PH_CMD;
                else if (b[7:1] == HCS_DATA_ADDR)
                  nxt_q.ph = b[0] ? HCS_PH_RD : HCS_PH_WR;
                else
                  nxt_q.ack_ok = 1'b0;
              end
              HCS_PH_CMD:
              begin
                // every command byte goes on, no limit on count
                nxt_q.mmu.cmd_valid = 1'b1;
                nxt_q.mmu.data      = b;
                nxt_q.mmu.ctx       = b;
                nxt_q.last_cmd      = b;
              end
              HCS_PH_WR:
              begin
                nxt_q.mmu.wr_valid = 1'b1;
                nxt_q.mmu.data     = b;
                nxt_q.mmu.ctx      = q.last_cmd;
              end
              default:
                nxt_q.ack_ok = 1'b0;
            endcase
          end
        end
        HCS_ST_MACK:
        begin
          // master nack ends the read; line is already released
          if (sda_s)
            nxt_q.st = HCS_ST_IDLE;
        end
        default:
          nxt_q.st = q.st;
      endcase
    end

    // drive point: the data line changes a delay after the clock fall
    if (fire_drv)
    begin
      case (q.st)
        HCS_ST_RECV:
        begin
          if (q.byte_done)
          begin
            nxt_q.byte_done = 1'b0;
            nxt_q.sda_oe    = q.ack_ok;
            nxt_q.st        = q.ack_ok ? HCS_ST_ACK : HCS_ST_IDLE;
          end
        end
        HCS_ST_ACK:
        begin
          if (q.ph == HCS_PH_RD)
            load = 1'b1;
          else
          begin
            nxt_q.sda_oe  = 1'b0;
            nxt_q.st      = HCS_ST_RECV;
            nxt_q.bit_cnt = 4'h0;
          end
        end
        HCS_ST_SEND:
        begin
          if (q.bit_cnt == HCS_BITS_PER_BYTE)
          begin
            // let the master drive its acknowledge
            nxt_q.sda_oe = 1'b0;
            nxt_q.st     = HCS_ST_MACK;
          end
          else
          begin
            nxt_q.sda_oe  = ~q.shreg[7];
            nxt_q.shreg   = {q.shreg[6:0], 1'b0};
            nxt_q.bit_cnt = q.bit_cnt + 4'h1;
          end
        end
        HCS_ST_MACK:
          load = 1'b1;
        default:
          nxt_q.st = q.st;
      endcase
    end

    // fetch a byte and put its top bit out at once
    if (load)
    begin
      nxt_q.mmu.rd_take = 1'b1;
      nxt_q.mmu.ctx     = q.last_cmd;
      nxt_q.sda_oe      = ~rd_byte[7];
      nxt_q.shreg       = {rd_byte[6:0], 1'b0};
      nxt_q.bit_cnt     = 4'h1;
      nxt_q.st          = HCS_ST_SEND;
    end

    // start wins over everything: new addressed transaction
    if (start_c)
    begin
      nxt_q.st        = HCS_ST_RECV;
      nxt_q.ph        = HCS_PH_ADDR;
      nxt_q.bit_cnt   = 4'h0;
      nxt_q.byte_done = 1'b0;
      nxt_q.sda_oe    = 1'b0;
      nxt_q.dly_run   = 1'b0;
    end
    else if (stop_c)
    begin
      nxt_q.st      = HCS_ST_IDLE;
      nxt_q.sda_oe  = 1'b0;
      nxt_q.dly_run = 1'b0;
    end

    // interrupt follows the hub's request level
    nxt_q.irq_oe = attention_req;

    // straps taken once the synchroniser has filled; mixed straps give mode 0
    if (!q.strap_done)
    begin
      nxt_q.strap_cnt = q.strap_cnt + 2'h1;
      if (q.strap_cnt == HCS_STRAP_WAIT)
      begin
        nxt_q.strap_done = 1'b1;
        nxt_q.mode1      = &ms_s;
      end
    end

    // mode 1: over-current reported for ports 2..5, indicators of ports 3..5 parked, port 2 keeps its indicator
    nxt_q.oc_flag  = q.mode1 ? ~oc_s : 4'h0;
    nxt_q.ind_n[0] = ~port_enabled[0];
    nxt_q.ind_n[3:1] = q.mode1 ? 3'h7 : ~port_enabled[3:1];

    // auxiliary clock: divide by twice the half period
    if (q.aux_cnt == HCS_AUX_HALF_CYC - 2'h1)
    begin
      nxt_q.aux_cnt = 2'h0;
      nxt_q.aux_clk = ~q.aux_clk;
    end
    else
      nxt_q.aux_cnt = q.aux_cnt + 2'h1;
  end

  // single state register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      q <= HCS_STATE_RST;
    else
      q <= nxt_q;
  end

  // outputs straight from the state register
  assign sda_out               = q.od_low;
  assign sda_oe                = q.sda_oe;
  assign irq_out_n             = q.od_low;
  assign irq_oe                = q.irq_oe;
  assign mmu_out               = q.mmu;
  assign mode1                 = q.mode1;
  assign port_overcurrent      = q.oc_flag;
  assign port2_indicator_out_n = q.ind_n[0];
  assign port_indicator_out_n  = q.ind_n[3:1];
  assign aux_clock_out         = q.aux_clk;

endmodule // hcs_slave
`default_nettype wire

//--- hcs_sync.sv
// two-flop synchroniser for a vector of pins
// assumes the bits are independent levels; no relation between bits is kept
`timescale 1ns/10ps
`default_nettype none
module hcs_sync
  import hcs_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  // both stages in one packed state
  typedef struct packed {
    logic [W-1:0] s1;  // first stage, read only by s2
    logic [W-1:0] s2;  // second stage, safe to use
  } hcs_sync_st_t;

  hcs_sync_st_t q;     // registered stages
  hcs_sync_st_t nxt_q; // next stages

  // shift the pins through two stages
  always_comb
  begin
    nxt_q    = q;
    nxt_q.s1 = d_in;
    nxt_q.s2 = q.s1;
  end

  // register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      q <= '0;
    else
      q <= nxt_q;
  end

  assign q_out = q.s2;

endmodule // hcs_sync
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the hub two-wire slave
// assumes hcs_master as bus partner and hcs_props bound to the slave
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top
  import hcs_pkg::*;
;
  logic       sys_clk;
  logic       srst;
  logic       scl;
  logic       sda_pull;
  logic       sda_oe;
  logic       irq_oe;
  logic       attention_req;
  hcs_mmu_t   mmu;
  logic [7:0] rd_byte;
  logic [1:0] sel;
  logic       mode1;
  logic [3:0] oc_n;
  logic [3:0] ocur;
  logic [3:0] port_enabled;
  logic       ind2;
  logic [2:0] ind;
  logic       aux;      // divided clock seen from outside
  logic       aux_was;  // its level one half period ago
  wire        sda_line = !(sda_oe || sda_pull); // pull-up on the data line
  int         num_errors = 0;
  int         total_checks = 0;
  logic [7:0] lfsr = 8'h14;
  logic [7:0] last_cmd;
  logic [7:0] b;
  logic       ack;
  hcs_mmu_t   got;
  hcs_mmu_t   exp_q[$]; // notes of bytes due at the memory side
  logic [1:0] straps [3] = '{2'h0, 2'h2, 2'h3}; // low, mixed, high

  hcs_slave u_hcs_slave (
    .sys_clk, .srst, .scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe,
    .irq_out_n(), .irq_oe, .attention_req, .mmu_out(mmu), .rd_byte,
    .mode_select_a(sel[1]), .mode_select_b(sel[0]), .mode1,
    .port2_overcurrent_in_n(oc_n[0]), .port3_overcurrent_in_n(oc_n[1]),
    .port4_overcurrent_in_n(oc_n[2]), .port5_overcurrent_in_n(oc_n[3]),
    .port_overcurrent(ocur), .port_enabled, .port2_indicator_out_n(ind2),
    .port_indicator_out_n(ind), .aux_clock_out(aux));

  hcs_master u_hcs_master (.sys_clk, .sda_line, .scl_pin(scl), .sda_pull);

  // 20 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic give_verdict();
    if (exp_q.size() != 0)
      num_errors++;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // byte out with the acknowledge we expect back
  task automatic send(input logic [7:0] d, input logic want);
    u_hcs_master.wr_byte(d, ack);
    `CHK(ack, want)
  endtask

  // command or data byte that the memory side must see, with its context
  task automatic put(input logic c, input logic [7:0] d);
    if (c)
      last_cmd = d;
    exp_q.push_back(hcs_mmu_t'{c, !c, 1'b0, d, last_cmd});
    send(d, 1'b1);
  endtask

  // watcher: each strobe takes the oldest note; none left means a stray byte
  // looked at on the falling edge, where the registered strobes have settled
  always @(negedge sys_clk)
    if (mmu.cmd_valid === 1'b1 || mmu.wr_valid === 1'b1 || mmu.rd_take === 1'b1)
    begin
      got = exp_q.size() > 0 ? exp_q.pop_front() : '0;
      `CHK(mmu, got)
    end

  // no hang outlives this bound
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    srst = 1'b1;
    attention_req = 1'b0;
    rd_byte = 8'h00;
    sel = 2'h0;
    oc_n = 4'hF;
    port_enabled = 4'h0;
    // three strap settings (low, mixed, high), each behind its own reset
    for (int m = 0; m < 3; m++)
    begin
      srst = 1'b1;
      sel = straps[m];
      u_hcs_master.cyc(4);
      srst = 1'b0;
      lfsr = lfsr_next(lfsr);
      oc_n = lfsr[3:0];
      port_enabled = lfsr[7:4];
      u_hcs_master.cyc(14);
      `CHK(mode1, m == 2)
      `CHK(ocur, m == 2 ? ~oc_n : 4'h0)
      `CHK({ind2, ind}, {~port_enabled[0], m == 2 ? 3'h7 : ~port_enabled[3:1]})
      // a stuck or too fast divider fails one of these two looks
      aux_was = aux;
      u_hcs_master.cyc(HCS_AUX_HALF_CYC);
      `CHK(aux, !aux_was)
      u_hcs_master.cyc(HCS_AUX_HALF_CYC);
      `CHK(aux, aux_was)
    end
    for (int i = 0; i < 2; i++)
    begin
      attention_req = !attention_req;
      u_hcs_master.cyc(2);
      `CHK(irq_oe, attention_req)
    end
    // commands, then data under repeated starts
    u_hcs_master.start();
    send(8'h36, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      lfsr = lfsr_next(lfsr);
      put(1'b1, lfsr);
    end
    u_hcs_master.start();
    send(8'h34, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      lfsr = lfsr_next(lfsr);
      put(1'b0, lfsr);
    end
    attention_req = 1'b1;
    u_hcs_master.start();
    send(8'h36, 1'b1);
    put(1'b1, 8'hF4);
    // one fetch per read byte; data still holds the last byte taken, the command
    for (int i = 0; i < 3; i++)
      exp_q.push_back(hcs_mmu_t'{1'b0, 1'b0, 1'b1, last_cmd, last_cmd});
    u_hcs_master.start();
    send(8'h35, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      lfsr = lfsr_next(lfsr);
      rd_byte = lfsr;
      u_hcs_master.get_byte(b, i < 2);
      `CHK(b, lfsr)
    end
    u_hcs_master.cyc(40);
    `CHK(sda_oe, 1'b0)
    u_hcs_master.stop();
    attention_req = 1'b0;
    // read at the command address and a foreign address: both ignored
    for (int i = 0; i < 2; i++)
    begin
      u_hcs_master.start();
      send(i == 0 ? 8'h37 : 8'hA0, 1'b0);
      send(8'h5A, 1'b0);
      u_hcs_master.stop();
    end
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
